// ---- hdl/sar_adc_cfg.svh ----
// Register offsets, field positions, reset values and timing counts of the converter
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH

// ==========================================================
// Register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_RESULT_HIGH 8'h04
`define OFS_AUX_TWO 8'h08
`define OFS_TRIG_CONFIG 8'h0C
`define OFS_TRIG_DELAY 8'h10
`define OFS_POWER 8'h14

// ==========================================================
// converter_control fields
`define CTRL_CH_LSB 0
`define CTRL_CH_MSB 2
`define CTRL_START 3
`define CTRL_DONE 4
`define CTRL_HW_EN 5
`define CTRL_RES0 6
`define CTRL_RES1 7

// auxiliary_control_two fields
`define AUX_OPAMP 0
`define AUX_CH1_SEL 1
`define AUX_RC_CLK 2

// trigger_config_reg fields
`define TRIG_SEL_LSB 0
`define TRIG_SEL_MSB 1
`define TRIG_TYPE_LSB 2
`define TRIG_TYPE_MSB 3

// power_control_reg fields
`define PWR_IDLE 0
`define PWR_DOWN 1

// ==========================================================
// Reset values
`define RST_BYTE 8'h00
`define RST_RESULT 10'h000

// ==========================================================
// Timing counts in converter clock cycles, result width and first trial code
`define SAMPLE_CYCLES 6'h04
`define BIT_CYCLES 6'h03
`define CONV_CYCLES 6'h22
`define MC_CYCLES 4'hC
`define RESULT_BITS 4'hA
`define SAR_FIRST_TRIAL 10'h200

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- hdl/sar_adc_pkg.sv ----
// Types shared by the converter control files
package sar_adc_pkg;

  // ==========================================================
  // Conversion sequencer states
  typedef enum logic [1:0]
  {
    CONV_IDLE = 2'b00,
    CONV_SAMPLE = 2'b01,
    CONV_APPROX = 2'b10
  } conv_state_e;

  // PWM trigger edge type
  typedef enum logic [1:0]
  {
    TRIG_RISE = 2'b00,
    TRIG_FALL = 2'b01,
    TRIG_CENTRE = 2'b10,
    TRIG_NONE = 2'b11
  } trig_type_e;

  // ==========================================================
  // Drive towards the analog macro
  typedef struct packed
  {
    logic [2:0] mux_channel;
    logic ch0_from_opamp;
    logic ch1_from_vbr;
    logic rc_clock_select;
    logic sample;
    logic [9:0] dac_code;
  } analog_ctrl_s;

  // Inputs from the PWM unit
  typedef struct packed
  {
    logic [2:0] even_out;
    logic centre_aligned;
    logic centre_point;
  } pwm_in_s;

endpackage

// ---- hdl/sar_step.sv ----
// One successive-approximation decision: keep or drop the trial bit, set the next trial
`timescale 1ns/1ps

module sar_step
(
  // Current approximation
  input wire logic [9:0] approx,
  input wire logic [3:0] bit_idx,
  // Comparator: input at or above the DAC voltage
  input wire logic comp_above,
  // Next approximation
  output logic [9:0] next_approx
);

  always_comb
  begin
    next_approx = approx;
    if (!comp_above)
    begin
      next_approx[bit_idx] = 1'b0;
    end
    if (bit_idx != 4'h0)
    begin
      next_approx[bit_idx - 4'h1] = 1'b1;
    end
  end

endmodule

// ---- hdl/sar_adc_conversion_control.sv ----
// Successive-approximation converter control with AXI4-Lite register access
`timescale 1ns/1ps
`include "sar_adc_cfg.svh"

module sar_adc_conversion_control
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Start sources
  input wire logic external_start_pin,
  input wire sar_adc_pkg::pwm_in_s pwm_in,
  // Analog macro
  input wire logic comp_above,
  output sar_adc_pkg::analog_ctrl_s analog_ctrl,
  // Processor side
  output logic adc_irq_req,
  output logic cpu_wake
);

  // ==========================================================
  // Registers
  logic [2:0] channel_reg;
  logic start_reg;
  logic done_reg;
  logic hw_en_reg;
  logic [9:0] result_reg;
  logic [7:0] aux_reg;
  logic [7:0] trig_cfg_reg;
  logic [7:0] trig_delay_reg;
  logic [1:0] power_reg;
  sar_adc_pkg::conv_state_e state_reg;
  logic [5:0] cyc_reg;
  logic [3:0] bit_reg;
  logic [9:0] approx_reg;
  logic [9:0] approx_next;
  logic wake_reg;

  // ==========================================================
  // AXI4-Lite slave
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;
  logic do_write;
  logic wr_ctrl;
  logic wr_aux;
  logic wr_trig;
  logic wr_dly;
  logic wr_pwr;
  logic wr_hit;
  logic [7:0] rd_byte;
  logic rd_hit;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_arready = !s_axi_rvalid;
  // Both halves in hand and the previous response gone
  assign do_write = ce && aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && !aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && !w_held_reg)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only byte lane 0 carries register bits; other lanes are ignored
  always_comb
  begin
    wr_hit = 1'b1;
    wr_ctrl = 1'b0;
    wr_aux = 1'b0;
    wr_trig = 1'b0;
    wr_dly = 1'b0;
    wr_pwr = 1'b0;
    unique case (aw_addr_reg)
      `OFS_CONTROL: wr_ctrl = do_write && w_lane0_reg;
      `OFS_RESULT_HIGH: wr_hit = 1'b1;
      `OFS_AUX_TWO: wr_aux = do_write && w_lane0_reg;
      `OFS_TRIG_CONFIG: wr_trig = do_write && w_lane0_reg;
      `OFS_TRIG_DELAY: wr_dly = do_write && w_lane0_reg;
      `OFS_POWER: wr_pwr = do_write && w_lane0_reg;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr[7:0])
      `OFS_CONTROL: rd_byte = {result_reg[1:0], hw_en_reg, done_reg, start_reg, channel_reg};
      `OFS_RESULT_HIGH: rd_byte = result_reg[9:2];
      `OFS_AUX_TWO: rd_byte = aux_reg;
      `OFS_TRIG_CONFIG: rd_byte = trig_cfg_reg;
      `OFS_TRIG_DELAY: rd_byte = trig_delay_reg;
      `OFS_POWER: rd_byte = {6'h00, power_reg};
      default:
      begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Plain configuration registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      channel_reg <= 3'h0;
      hw_en_reg <= 1'b0;
      aux_reg <= `RST_BYTE;
      trig_cfg_reg <= `RST_BYTE;
      trig_delay_reg <= `RST_BYTE;
    end
    else if (ce)
    begin
      if (wr_ctrl)
      begin
        channel_reg <= w_data_reg[`CTRL_CH_MSB:`CTRL_CH_LSB];
        hw_en_reg <= w_data_reg[`CTRL_HW_EN];
      end
      if (wr_aux)
      begin
        aux_reg <= w_data_reg;
      end
      if (wr_trig)
      begin
        trig_cfg_reg <= w_data_reg;
      end
      if (wr_dly)
      begin
        trig_delay_reg <= w_data_reg;
      end
    end
  end

  // ==========================================================
  // External start pin qualification
  logic [3:0] low_cnt_reg;
  logic [3:0] high_cnt_reg;
  logic armed_reg;
  logic pin_start;

  // A glitch shorter than a machine cycle neither arms nor fires
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      low_cnt_reg <= 4'h0;
      high_cnt_reg <= 4'h0;
      armed_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (!external_start_pin)
      begin
        high_cnt_reg <= 4'h0;
        if (low_cnt_reg != `MC_CYCLES)
        begin
          low_cnt_reg <= low_cnt_reg + 4'h1;
        end
        // The twelfth low sample completes the machine cycle, so a minimum pulse arms
        if (low_cnt_reg >= `MC_CYCLES - 4'h1)
        begin
          armed_reg <= 1'b1;
        end
      end
      else
      begin
        low_cnt_reg <= 4'h0;
        if (high_cnt_reg != `MC_CYCLES)
        begin
          high_cnt_reg <= high_cnt_reg + 4'h1;
        end
        if (pin_start)
        begin
          armed_reg <= 1'b0;
        end
      end
    end
  end

  // Idle mode does not gate this path
  assign pin_start = armed_reg && external_start_pin && (high_cnt_reg == `MC_CYCLES);

  // ==========================================================
  // PWM trigger with programmed delay
  logic [2:0] pwm_prev_reg;
  logic centre_prev_reg;
  logic pwm_level;
  logic pwm_prev;
  logic pwm_event;
  logic delay_busy_reg;
  logic [7:0] delay_cnt_reg;
  logic pwm_start;
  sar_adc_pkg::trig_type_e trig_type;
  logic [1:0] trig_sel;

  assign trig_type = sar_adc_pkg::trig_type_e'(trig_cfg_reg[`TRIG_TYPE_MSB:`TRIG_TYPE_LSB]);
  assign trig_sel = trig_cfg_reg[`TRIG_SEL_MSB:`TRIG_SEL_LSB];
  // Selection 3 has no even channel behind it; rise and fall types never trigger on it
  assign pwm_level = (trig_sel == 2'h3) ? 1'b0 : pwm_in.even_out[trig_sel];
  assign pwm_prev = (trig_sel == 2'h3) ? 1'b0 : pwm_prev_reg[trig_sel];

  always_comb
  begin
    unique case (trig_type)
      sar_adc_pkg::TRIG_RISE: pwm_event = pwm_level && !pwm_prev;
      sar_adc_pkg::TRIG_FALL: pwm_event = !pwm_level && pwm_prev && (trig_sel != 2'h3);
      // Shared counter centre point: same instant for any channel
      sar_adc_pkg::TRIG_CENTRE: pwm_event = pwm_in.centre_aligned && pwm_in.centre_point && !centre_prev_reg;
      sar_adc_pkg::TRIG_NONE: pwm_event = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pwm_prev_reg <= 3'h0;
      centre_prev_reg <= 1'b0;
      delay_busy_reg <= 1'b0;
      delay_cnt_reg <= 8'h00;
    end
    else if (ce)
    begin
      pwm_prev_reg <= pwm_in.even_out;
      centre_prev_reg <= pwm_in.centre_point;
      if (!delay_busy_reg && hw_en_reg && pwm_event)
      begin
        delay_busy_reg <= 1'b1;
        delay_cnt_reg <= trig_delay_reg;
      end
      else if (delay_busy_reg)
      begin
        if (delay_cnt_reg == 8'h00)
        begin
          delay_busy_reg <= 1'b0;
        end
        else
        begin
          delay_cnt_reg <= delay_cnt_reg - 8'h01;
        end
      end
    end
  end

  assign pwm_start = delay_busy_reg && (delay_cnt_reg == 8'h00);

  // ==========================================================
  // Conversion sequencer
  logic sw_start;
  logic hw_start;
  logic begin_conv;
  logic bit_decide;
  logic conv_end;

  assign sw_start = wr_ctrl && w_data_reg[`CTRL_START];
  assign hw_start = hw_en_reg && (pin_start || pwm_start);
  assign begin_conv = (state_reg == sar_adc_pkg::CONV_IDLE) && (sw_start || hw_start);
  assign bit_decide = (state_reg == sar_adc_pkg::CONV_APPROX)
    && (cyc_reg >= `SAMPLE_CYCLES)
    && ((6'(cyc_reg - `SAMPLE_CYCLES) % `BIT_CYCLES) == (`BIT_CYCLES - 6'h01));
  assign conv_end = bit_decide && (cyc_reg == (`CONV_CYCLES - 6'h01));

  sar_step i_sar_step
  (
    .approx(approx_reg),
    .bit_idx(bit_reg),
    .comp_above(comp_above),
    .next_approx(approx_next)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= sar_adc_pkg::CONV_IDLE;
      cyc_reg <= 6'h00;
      bit_reg <= 4'h0;
      approx_reg <= `RST_RESULT;
    end
    else if (ce)
    begin
      unique case (state_reg)
        sar_adc_pkg::CONV_IDLE:
        begin
          if (begin_conv)
          begin
            state_reg <= sar_adc_pkg::CONV_SAMPLE;
            cyc_reg <= 6'h00;
          end
        end
        sar_adc_pkg::CONV_SAMPLE:
        begin
          cyc_reg <= cyc_reg + 6'h01;
          if (cyc_reg == `SAMPLE_CYCLES - 6'h01)
          begin
            state_reg <= sar_adc_pkg::CONV_APPROX;
            bit_reg <= `RESULT_BITS - 4'h1;
            approx_reg <= `SAR_FIRST_TRIAL;
          end
        end
        sar_adc_pkg::CONV_APPROX:
        begin
          cyc_reg <= cyc_reg + 6'h01;
          if (bit_decide)
          begin
            approx_reg <= approx_next;
            bit_reg <= bit_reg - 4'h1;
          end
          if (conv_end)
          begin
            state_reg <= sar_adc_pkg::CONV_IDLE;
          end
        end
        default:
        begin
          state_reg <= sar_adc_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Start bit, done flag, result
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      start_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (conv_end)
      begin
        start_reg <= 1'b0;
      end
      else if (begin_conv)
      begin
        start_reg <= 1'b1;
      end
    end
  end

  // Completion wins over a software clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      done_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (conv_end)
      begin
        done_reg <= 1'b1;
      end
      else if (wr_ctrl && !w_data_reg[`CTRL_DONE])
      begin
        done_reg <= 1'b0;
      end
    end
  end

  // Code is the final approximation: 000 at the bottom of range, 3FF at the top
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      result_reg <= `RST_RESULT;
    end
    else if (ce && conv_end && !done_reg)
    begin
      result_reg <= approx_next;
    end
  end

  // ==========================================================
  // Power control and wake
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      power_reg <= 2'h0;
      wake_reg <= 1'b0;
    end
    else if (ce)
    begin
      wake_reg <= 1'b0;
      if (conv_end && (power_reg != 2'h0))
      begin
        power_reg <= 2'h0;
        wake_reg <= 1'b1;
      end
      else if (wr_pwr)
      begin
        power_reg <= {w_data_reg[`PWR_DOWN], w_data_reg[`PWR_IDLE]};
      end
    end
  end

  assign cpu_wake = wake_reg;
  assign adc_irq_req = done_reg;

  // ==========================================================
  // Analog drive
  always_comb
  begin
    analog_ctrl.mux_channel = channel_reg;
    analog_ctrl.ch0_from_opamp = aux_reg[`AUX_OPAMP];
    analog_ctrl.ch1_from_vbr = aux_reg[`AUX_CH1_SEL];
    analog_ctrl.rc_clock_select = aux_reg[`AUX_RC_CLK];
    analog_ctrl.sample = (state_reg == sar_adc_pkg::CONV_SAMPLE);
    analog_ctrl.dac_code = approx_reg;
  end

endmodule

// ---- tb/analog_model.sv ----
// Analog front end model: per-channel input codes and an ideal comparator
`timescale 1ns/1ps

module analog_model
(
  // Drive from the converter
  input wire sar_adc_pkg::analog_ctrl_s analog_ctrl,
  // Input levels as ideal codes
  input wire logic [7:0][9:0] vin,
  input wire logic [9:0] vin_opamp,
  input wire logic [9:0] vin_vbr,
  // Comparator
  output logic comp_above
);
  logic [9:0] sel_vin;

  // ==========================================================
  // Input selection
  always_comb
  begin
    sel_vin = vin[analog_ctrl.mux_channel];
    if (analog_ctrl.mux_channel == 3'h0 && analog_ctrl.ch0_from_opamp)
      sel_vin = vin_opamp;
    if (analog_ctrl.mux_channel == 3'h1 && analog_ctrl.ch1_from_vbr)
      sel_vin = vin_vbr;
  end

  // A tie counts as above, so the search lands exactly on the input code
  assign comp_above = sel_vin >= analog_ctrl.dac_code;
endmodule

// ---- tb/sar_adc_checker.sv ----
// Concurrent checks on the converter control ports
`timescale 1ns/1ps

module sar_adc_checker
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Converter side
  input wire sar_adc_pkg::analog_ctrl_s analog_ctrl,
  input wire logic adc_irq_req,
  input wire logic cpu_wake
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Cycles since a conversion began; back at zero before the earliest restart
  logic [5:0] run_cnt;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      run_cnt <= 6'h00;
    else if ($rose(analog_ctrl.sample))
      run_cnt <= 6'h01;
    else if (run_cnt != 6'h00 && run_cnt < 6'h21)
      run_cnt <= run_cnt + 6'h01;
    else
      run_cnt <= 6'h00;
  end

  // ==========================================================
  // Sequences
  sequence s_sampling;
    analog_ctrl.sample [*4] ##1 !analog_ctrl.sample;
  endsequence

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  // ==========================================================
  // Properties
  property p_sample_len;
    $rose(analog_ctrl.sample) |-> s_sampling;
  endproperty
  a_sample_len: assert property (p_sample_len)
    else $error("sample phase length wrong");

  property p_conv_len;
    $rose(analog_ctrl.sample) && !adc_irq_req |-> ##33 !adc_irq_req ##1 adc_irq_req;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("done flag not set 34 cycles after start");

  property p_no_restart;
    $rose(analog_ctrl.sample) |-> run_cnt == 6'h00;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("conversion restarted while busy");

  property p_done_hold;
    $fell(adc_irq_req) |-> $rose(s_axi_bvalid);
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done flag fell without a register write");

  property p_wake;
    cpu_wake |-> adc_irq_req ##1 !cpu_wake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake pulse without done or too long");

  property p_select;
    $changed(analog_ctrl.mux_channel) || $changed(analog_ctrl.ch0_from_opamp) ||
      $changed(analog_ctrl.ch1_from_vbr) |-> $rose(s_axi_bvalid);
  endproperty
  a_select: assert property (p_select)
    else $error("input selection changed without a write");

  property p_wr_answer;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response late");

  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read response late");
endmodule

bind sar_adc_conversion_control sar_adc_checker i_sar_adc_checker
(
  .clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .analog_ctrl(analog_ctrl), .adc_irq_req(adc_irq_req), .cpu_wake(cpu_wake)
);

// ---- tb/test_sar_adc_conversion_control.sv ----
// Self-checking bench for the converter control
`timescale 1ns/1ps
`include "sar_adc_cfg.svh"

module test_sar_adc_conversion_control;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rdat;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, comp, irq, wake;
  logic [1:0] bresp, rresp, resp;
  logic pin = 1'b1;
  sar_adc_pkg::pwm_in_s pwm = '0;
  sar_adc_pkg::analog_ctrl_s actl;
  logic [7:0][9:0] vin = {10'h2D8, 10'h123, 10'h3FE, 10'h001, 10'h2AA, 10'h155, 10'h3FF, 10'h000};
  logic [9:0] vop = 10'h0C3, vbr = 10'h16D;
  int n_errors = 0, compares = 0, cyc = 0, n_wake = 0;

  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (wake === 1'b1) n_wake++;

  // ==========================================================
  // Instances
  sar_adc_conversion_control i_sar_adc_conversion_control
  (
    .clk(clk), .rst_n(rst_n), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_start_pin(pin), .pwm_in(pwm), .comp_above(comp), .analog_ctrl(actl),
    .adc_irq_req(irq), .cpu_wake(wake)
  );

  analog_model i_analog_model
  (
    .analog_ctrl(actl), .vin(vin), .vin_opamp(vop), .vin_vbr(vbr), .comp_above(comp)
  );

  // ==========================================================
  // Bus and compare tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= {24'h0, a};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    rdat = rdata;
    resp = rresp;
  endtask

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!irq && n < lim);
  endtask

  task automatic sw_conv(input logic [2:0] ch, input logic [9:0] exp);
    int t0;
    wr(`OFS_CONTROL, {5'h01, ch});
    t0 = cyc;
    wait_irq(60);
    check(cyc - t0, 34, "conversion time");
    rd(`OFS_CONTROL);
    check(rdat, {24'h0, exp[1:0], 3'h2, ch}, "control");
    rd(`OFS_RESULT_HIGH);
    check(rdat, {24'h0, exp[9:2]}, "result high");
    check(actl.mux_channel, ch, "mux");
  endtask

  task automatic pin_pulse(input int lo);
    @(posedge clk);
    pin <= 1'b0;
    repeat (lo) @(posedge clk);
    pin <= 1'b1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd(`OFS_CONTROL);
    check(rdat, 32'h0, "control reset");
    wr(`OFS_RESULT_HIGH, 8'hFF);
    rd(`OFS_RESULT_HIGH);
    check(rdat, 32'h0, "result read-only");
    rd(8'h18);
    check({rdat[29:0], resp}, {30'h0, `RESP_SLVERR}, "unmapped read");
    wr(8'h18, 8'hFF);
    check(resp, `RESP_SLVERR, "unmapped write");
    $display("test registers done");
  endtask

  task automatic t_chan();
    for (int c = 0; c < 8; c++)
    begin
      sw_conv(3'(c), vin[c]);
      wr(`OFS_CONTROL, 8'(c));
    end
    wr(`OFS_AUX_TWO, 8'h03);
    sw_conv(3'h0, vop);
    wr(`OFS_CONTROL, 8'h00);
    sw_conv(3'h1, vbr);
    wr(`OFS_CONTROL, 8'h01);
    wr(`OFS_AUX_TWO, 8'h00);
    $display("test channels done");
  endtask

  task automatic t_busy();
    int t0;
    wr(`OFS_CONTROL, 8'h0A);
    t0 = cyc;
    repeat (10) @(posedge clk);
    wr(`OFS_CONTROL, 8'h0A);
    wait_irq(60);
    check(cyc - t0, 34, "start while busy");
    vin[2] <= 10'h0F0;
    wr(`OFS_CONTROL, 8'h1A);
    repeat (40) @(posedge clk);
    rd(`OFS_RESULT_HIGH);
    check(rdat, 32'h55, "result held while done");
    wr(`OFS_CONTROL, 8'h02);
    sw_conv(3'h2, 10'h0F0);
    wr(`OFS_CONTROL, 8'h02);
    $display("test busy done");
  endtask

  task automatic t_pin();
    pin_pulse(12);
    wait_irq(60);
    check(irq, 1'b0, "pin start with hw off");
    wr(`OFS_CONTROL, 8'h20);
    wr(`OFS_POWER, 8'h01);
    pin_pulse(12);
    wait_irq(80);
    check(irq, 1'b1, "pin start in idle");
    rd(`OFS_POWER);
    check(rdat, 32'h0, "idle exit");
    check(n_wake, 32'h1, "idle wake");
    wr(`OFS_CONTROL, 8'h20);
    pin_pulse(11);
    wait_irq(60);
    check(irq, 1'b0, "short low level");
    wr(`OFS_AUX_TWO, 8'h04);
    check(actl.rc_clock_select, 1'b1, "rc clock select");
    wr(`OFS_CONTROL, 8'h08);
    wr(`OFS_POWER, 8'h02);
    wait_irq(60);
    rd(`OFS_POWER);
    check(rdat, 32'h0, "powerdown exit");
    check(n_wake, 32'h2, "powerdown wake");
    wr(`OFS_CONTROL, 8'h00);
    $display("test pin and power done");
  endtask

  task automatic pwm_try(input logic [1:0] sel, input logic [1:0] typ, output int n);
    int t0;
    wr(`OFS_CONTROL, 8'h00);
    pwm.even_out <= (typ == 2'h1) ? 3'h7 : 3'h0;
    pwm.centre_aligned <= (typ == 2'h2);
    pwm.centre_point <= 1'b0;
    wr(`OFS_TRIG_CONFIG, {4'h0, typ, sel});
    wr(`OFS_TRIG_DELAY, 8'h14);
    wr(`OFS_CONTROL, 8'h20);
    @(posedge clk);
    if (typ == 2'h2)
      pwm.centre_point <= 1'b1;
    else
      pwm.even_out[sel] <= (typ == 2'h0);
    t0 = cyc;
    wait_irq(100);
    n = cyc - t0;
    check(n >= 54 && n <= 62, 1'b1, "pwm delayed start");
  endtask

  task automatic t_pwm();
    int n, nc;
    nc = 0;
    for (int s = 0; s < 3; s++)
      for (int t = 0; t < 3; t++)
      begin
        pwm_try(2'(s), 2'(t), n);
        if (t == 2 && s == 0) nc = n;
        if (t == 2) check(n, nc, "centre instant");
      end
    wr(`OFS_TRIG_CONFIG, 8'h0F);
    wr(`OFS_CONTROL, 8'h00);
    $display("test pwm done");
  endtask

  // ==========================================================
  // Run control
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_chan();
    t_busy();
    t_pin();
    t_pwm();
    finish_test();
  end

  // Whole run needs about 1500 cycles; over ten times that means a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
